// *** verilog/tmz_timer.sv ***
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tmz_cfg.svh"
// Operation
// (R1) counter is an 8-bit up counter stepping once per selected count clock
// (R2) counting runs only while mode bit 7 is set
// (R3) wrap from FF to 00 sets the overflow flag
// (R4) overflow flag stays set until software writes it to zero
// (R5) enabled overflow raises an interrupt request toward vector 8
// (R6) reload on overflow if auto-reload set, always in PWM mode
// (R7) reload writes land in a buffer, applied at next overflow
// (R8) mode bit 3 selects event counting on the input pin
// (R9) slow path divides instruction clock by 256 down to 2
// (R10) fast path divides oscillator clock by 128 down to 1
// (R11) prescale code lives in mode bits 6 to 4
// (R12) PWM enable bit 0 drives the PWM waveform on the output pin
// (R13) buzzer toggles the pin each overflow when PWM is off
// (R14) in PWM mode buzzer and auto-reload bits pick the period
// (R15) event counter mode holds the external pin interrupt flag at zero
// (R16) low-power mode keeps running; wake on overflow only if enabled
// (R17) software configures fully before setting the enable bit
// (R18) 256 steps, one per selected clock period
// (R19) PWM overflows every 256, 64, 32 or 16 counts
// (R20) fast clock select is bit 2 of a second mode register
// (R21) event pin synchronised, one count per rising edge
// (R22) PWM output high from reload until overflow boundary
module tmz_timer
    import tmz_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // rate sources
    input wire logic cpu_tick,
    input wire logic hosc_tick,
    // pins and system
    input wire logic event_input_pin,
    input wire logic ext_int_event,
    input wire logic green_mode,
    output logic pwm_pin_out,
    output logic pwm_pin_oe,
    output logic overflow_irq,
    output logic green_wake,
    output logic ext_int_flag
);
    tmz_mode_t mode_ff, nxt_mode;
    logic [7:0] count_ff, nxt_count;
    logic [7:0] reload_buf_ff, nxt_reload_buf;
    logic fast_ff, nxt_fast;
    logic gwake_ff, nxt_gwake;
    logic ien_ff, nxt_ien;
    logic ovf_ff, nxt_ovf;
    logic buz_ff, nxt_buz;
    logic pwm_ff, nxt_pwm;
    logic wake_ff, nxt_wake;
    logic eint_ff, nxt_eint;
    logic [2:0] evs_ff;
    logic aw_ff, nxt_aw, w_ff, nxt_w;
    logic [11:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    tmz_bus_st_t bst_ff, nxt_bst;
    logic [1:0] bresp_ff, nxt_bresp;
    tmz_bus_st_t rst_st_ff, nxt_rst_st;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    tmz_wr_t wr;
    logic pre_tick, ev_rise, step, wrap, ovf_ev;
    logic [7:0] bmask;

    // address decode shared by read and write paths
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `TMZ_ADDR_MODE) || (a == `TMZ_ADDR_COUNT) ||
                   (a == `TMZ_ADDR_RELOAD) || (a == `TMZ_ADDR_CLKSEL) ||
                   (a == `TMZ_ADDR_STATUS);
    endfunction

    tmz_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cpu_tick(cpu_tick),
        .hosc_tick(hosc_tick),
        .fast_sel(fast_ff), // [R20]
        .rate(mode_ff.rate), // [R11]
        .tick(pre_tick)
    );

    // event pin: two-flop synchroniser then edge stage [R21]
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            evs_ff <= 3'b000;
        end else begin
            evs_ff <= {evs_ff[1:0], event_input_pin};
        end
    end
    assign ev_rise = evs_ff[1] && !evs_ff[2]; // [R21]

    // count step: pin edges in event mode, else prescaled clock [R8] [R18]
    assign step = mode_ff.enb && (mode_ff.ext ? ev_rise : pre_tick); // [R2] [R8]
    // PWM boundary mask picks 256/64/32/16 count period [R19] [R14]
    always_comb begin
        case ({mode_ff.aload, mode_ff.buz})
            2'b01: bmask = `TMZ_MASK_64;
            2'b10: bmask = `TMZ_MASK_32;
            2'b11: bmask = `TMZ_MASK_16;
            default: bmask = `TMZ_CNT_MAX;
        endcase
    end
    // overflow: FF to 00, or the PWM boundary in PWM mode [R3] [R19]
    assign wrap = mode_ff.pwm ? ((count_ff & bmask) == bmask) : (count_ff == `TMZ_CNT_MAX);
    assign ovf_ev = step && wrap;

    assign wr = {aw_ff && w_ff, awaddr_ff, wdata_ff, wstrb_ff}; // commit once both halves held

    // timer core and register writes
    always_comb begin
        nxt_mode = mode_ff;
        nxt_count = count_ff;
        nxt_reload_buf = reload_buf_ff;
        nxt_fast = fast_ff;
        nxt_gwake = gwake_ff;
        nxt_ien = ien_ff;
        nxt_ovf = ovf_ff;
        nxt_buz = buz_ff;
        nxt_pwm = pwm_ff;
        nxt_eint = eint_ff;
        if (wr.en && wr.strb[0]) begin
            case (wr.addr)
                `TMZ_ADDR_MODE: nxt_mode = tmz_mode_t'(wr.data[7:0]); // [R11]
                `TMZ_ADDR_COUNT: nxt_count = wr.data[7:0];
                `TMZ_ADDR_RELOAD: nxt_reload_buf = wr.data[7:0]; // [R7]
                `TMZ_ADDR_CLKSEL: begin
                    nxt_fast = wr.data[`TMZ_B_FAST]; // [R20]
                    nxt_gwake = wr.data[`TMZ_B_GWAKE];
                end
                `TMZ_ADDR_STATUS: begin
                    nxt_ien = wr.data[`TMZ_B_IEN];
                    if (!wr.data[`TMZ_B_OVF]) begin
                        nxt_ovf = 1'b0; // software clear only [R4]
                    end
                end
                default: ;
            endcase
        end
        // counter steps after any register write so hardware wins the cycle
        if (step) begin
            nxt_count = count_ff + 8'h01; // [R1] [R18]
            nxt_pwm = pwm_ff;
            if (ovf_ev) begin
                nxt_ovf = 1'b1; // set wins over clear [R3] [R4]
                if (mode_ff.pwm || mode_ff.aload) begin
                    nxt_count = reload_buf_ff; // buffered value moves in [R6] [R7]
                    nxt_pwm = 1'b1; // [R22]
                end else begin
                    nxt_count = 8'h00;
                end
                if (!mode_ff.pwm) begin
                    nxt_buz = ~buz_ff; // [R13] [R14]
                end
            end
        end
        // PWM stays high from reload up to the boundary, then drops [R22]
        if (mode_ff.pwm && step && ((count_ff & bmask) == (bmask - 8'h01))) begin
            nxt_pwm = 1'b0;
        end
        // external pin interrupt flag blocked in event mode [R15]
        if (mode_ff.ext) begin
            nxt_eint = 1'b0;
        end else if (ext_int_event) begin
            nxt_eint = 1'b1;
        end else if (wr.en && wr.strb[0] && (wr.addr == `TMZ_ADDR_STATUS) &&
                     !wr.data[`TMZ_B_EINT]) begin
            nxt_eint = 1'b0;
        end
        // low-power wake on overflow when enabled [R16]
        nxt_wake = green_mode && gwake_ff && ovf_ev;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_ff <= tmz_mode_t'(`TMZ_RST_BYTE);
            count_ff <= `TMZ_RST_BYTE;
            reload_buf_ff <= `TMZ_RST_BYTE;
            fast_ff <= 1'b0;
            gwake_ff <= 1'b0;
            ien_ff <= 1'b0;
            ovf_ff <= 1'b0;
            buz_ff <= 1'b0;
            pwm_ff <= 1'b0;
            wake_ff <= 1'b0;
            eint_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            count_ff <= nxt_count;
            reload_buf_ff <= nxt_reload_buf;
            fast_ff <= nxt_fast;
            gwake_ff <= nxt_gwake;
            ien_ff <= nxt_ien;
            ovf_ff <= nxt_ovf;
            buz_ff <= nxt_buz;
            pwm_ff <= nxt_pwm;
            wake_ff <= nxt_wake;
            eint_ff <= nxt_eint;
        end
    end

    // pin: PWM has priority, buzzer only with PWM off, else left to GPIO [R12] [R13]
    assign pwm_pin_oe = mode_ff.pwm || mode_ff.buz;
    assign pwm_pin_out = mode_ff.pwm ? pwm_ff : (mode_ff.buz && buz_ff);
    // level request while flag and enable are both set [R5]
    assign overflow_irq = ovf_ff && ien_ff;
    assign green_wake = wake_ff; // [R16]
    assign ext_int_flag = eint_ff;

    // write channel: take address and data in either order
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bst = bst_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        case (bst_ff)
            TMZ_IDLE: begin
                if (aw_ff && w_ff) begin
                    nxt_aw = 1'b0;
                    nxt_w = 1'b0;
                    nxt_bst = TMZ_RESP;
                    nxt_bresp = addr_hit(awaddr_ff) ? `TMZ_RESP_OK : `TMZ_RESP_ERR;
                end
            end
            TMZ_RESP: begin
                if (s_axi_bready) begin
                    nxt_bst = TMZ_IDLE;
                end
            end
            default: nxt_bst = TMZ_IDLE;
        endcase
    end

    // read channel: one read at a time, answer one cycle after the address
    always_comb begin
        nxt_rst_st = rst_st_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        case (rst_st_ff)
            TMZ_IDLE: begin
                if (s_axi_arvalid) begin
                    nxt_rst_st = TMZ_RESP;
                    nxt_rresp = addr_hit(s_axi_araddr) ? `TMZ_RESP_OK : `TMZ_RESP_ERR;
                    case (s_axi_araddr)
                        `TMZ_ADDR_MODE: nxt_rdata = {24'h000000, mode_ff};
                        `TMZ_ADDR_COUNT: nxt_rdata = {24'h000000, count_ff};
                        // reload register is write-only; reads see zero
                        `TMZ_ADDR_CLKSEL: nxt_rdata = {29'h00000000, fast_ff, gwake_ff, 1'b0};
                        `TMZ_ADDR_STATUS: nxt_rdata = {29'h00000000, eint_ff, ien_ff, ovf_ff};
                        default: nxt_rdata = 32'h00000000;
                    endcase
                end
            end
            TMZ_RESP: begin
                if (s_axi_rready) begin
                    nxt_rst_st = TMZ_IDLE;
                end
            end
            default: nxt_rst_st = TMZ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bst_ff <= TMZ_IDLE;
            bresp_ff <= `TMZ_RESP_OK;
            rst_st_ff <= TMZ_IDLE;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `TMZ_RESP_OK;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bst_ff <= nxt_bst;
            bresp_ff <= nxt_bresp;
            rst_st_ff <= nxt_rst_st;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // handshakes: accept a channel only while its slot is empty
    assign s_axi_awready = !aw_ff && (bst_ff == TMZ_IDLE);
    assign s_axi_wready = !w_ff && (bst_ff == TMZ_IDLE);
    assign s_axi_bvalid = (bst_ff == TMZ_RESP);
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = (rst_st_ff == TMZ_IDLE);
    assign s_axi_rvalid = (rst_st_ff == TMZ_RESP);
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule

// *** pkg/tmz_cfg.svh ***
`ifndef TMZ_CFG_SVH
`define TMZ_CFG_SVH
// register indices, and byte addresses on the bus at four times the index
`define TMZ_IDX_MODE 8'hDA
`define TMZ_IDX_COUNT 8'hDB
`define TMZ_IDX_RELOAD 8'hCD
`define TMZ_IDX_CLKSEL 8'hD8
`define TMZ_IDX_STATUS 8'hDC
`define TMZ_ADDR_MODE 12'h368
`define TMZ_ADDR_COUNT 12'h36C
`define TMZ_ADDR_RELOAD 12'h334
`define TMZ_ADDR_CLKSEL 12'h360
`define TMZ_ADDR_STATUS 12'h370
// mode_control fields
`define TMZ_B_PWM 0
`define TMZ_B_BUZ 1
`define TMZ_B_ALOAD 2
`define TMZ_B_EXT 3
`define TMZ_B_RATE_LO 4
`define TMZ_B_RATE_HI 6
`define TMZ_B_ENB 7
// clock select register fields
`define TMZ_B_GWAKE 1
`define TMZ_B_FAST 2
// status register fields
`define TMZ_B_OVF 0
`define TMZ_B_IEN 1
`define TMZ_B_EINT 2
`define TMZ_RST_BYTE 8'h00
`define TMZ_CNT_MAX 8'hFF
`define TMZ_MASK_64 8'h3F
`define TMZ_MASK_32 8'h1F
`define TMZ_MASK_16 8'h0F
`define TMZ_PRE_W 8
`define TMZ_SHIFT_SLOW 4'h8
`define TMZ_SHIFT_FAST 4'h7
`define TMZ_RESP_OK 2'b00
`define TMZ_RESP_ERR 2'b10
`endif

// *** pkg/tmz_pkg.sv ***
package tmz_pkg;
    // one bus write as seen by the register logic
    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } tmz_wr_t;
    // mode_control bit layout
    typedef struct packed {
        logic enb;
        logic [2:0] rate;
        logic ext;
        logic aload;
        logic buz;
        logic pwm;
    } tmz_mode_t;
    typedef enum logic [1:0] {
        TMZ_IDLE,
        TMZ_RESP
    } tmz_bus_st_t;
endpackage

// *** verilog/tmz_prescaler.sv ***
`timescale 1ns/1ps
`include "tmz_cfg.svh"
// free running divider; emits one-cycle count enables for the selected rate
module tmz_prescaler
    import tmz_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // rate sources and selection
    input wire logic cpu_tick,
    input wire logic hosc_tick,
    input wire logic fast_sel,
    input wire logic [2:0] rate,
    // count enable
    output logic tick
);
    logic [`TMZ_PRE_W-1:0] div_ff;
    logic [`TMZ_PRE_W-1:0] nxt_div;
    logic src;
    logic [3:0] shift;
    logic [`TMZ_PRE_W-1:0] mask;

    // base tick: instruction clock or fast oscillator [R9] [R10]
    assign src = fast_sel ? hosc_tick : cpu_tick;
    // code 000b divides by 256 (or 128 on the fast path), 111b by 2 (or 1)
    assign shift = fast_sel ? (`TMZ_SHIFT_FAST - {1'b0, rate}) : (`TMZ_SHIFT_SLOW - {1'b0, rate});
    assign mask = `TMZ_PRE_W'((9'h001 << shift) - 9'h001);

    always_comb begin
        nxt_div = div_ff;
        if (src) begin
            nxt_div = div_ff + `TMZ_PRE_W'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // fires once every 2^shift source ticks [R9] [R10]
    assign tick = src && ((div_ff & mask) == mask);
endmodule

// *** tb/tmz_timer_checker.sv ***
`timescale 1ns/1ps
`include "tmz_cfg.svh"
// port watcher; shadows mode and clock select writes seen on the bus
module tmz_timer_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // pins and system
    input wire logic green_mode,
    input wire logic pwm_pin_oe,
    input wire logic overflow_irq,
    input wire logic green_wake,
    input wire logic ext_int_flag
);
    logic [11:0] addr_ff;
    logic [7:0] data_ff;
    logic [7:0] mode_ff;
    logic [7:0] csel_ff;
    logic bvalid_ff;
    logic mapped;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // shadows lag the design by a cycle, so the mode checks skip cycles with a response up
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_ff <= 12'h000;
            data_ff <= 8'h00;
            mode_ff <= 8'h00;
            csel_ff <= 8'h00;
            bvalid_ff <= 1'b0;
        end else begin
            bvalid_ff <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) addr_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) data_ff <= s_axi_wdata[7:0];
            if (s_axi_bvalid && !bvalid_ff && addr_ff == `TMZ_ADDR_MODE) mode_ff <= data_ff;
            if (s_axi_bvalid && !bvalid_ff && addr_ff == `TMZ_ADDR_CLKSEL) csel_ff <= data_ff;
        end
    end
    // decoded register map
    assign mapped = addr_ff inside {`TMZ_ADDR_MODE, `TMZ_ADDR_COUNT, `TMZ_ADDR_RELOAD,
        `TMZ_ADDR_CLKSEL, `TMZ_ADDR_STATUS};
    property p_ext_quiet; !s_axi_bvalid && mode_ff[3] |-> !ext_int_flag; endproperty
    a_ext_quiet: assert property (p_ext_quiet) else $error("pin flag up in event mode");
    property p_oe; !s_axi_bvalid |-> pwm_pin_oe == (mode_ff[0] | mode_ff[1]); endproperty
    a_oe: assert property (p_oe) else $error("pin enable disagrees with mode");
    property p_wake_pulse; green_wake |=> !green_wake; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
    property p_wake_cause; green_wake |-> $past(green_mode); endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake outside low power");
    property p_wake_en; green_wake |-> csel_ff[1]; endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake while not enabled");
    property p_stopped; !s_axi_bvalid && !mode_ff[7] |-> !green_wake; endproperty
    a_stopped: assert property (p_stopped) else $error("overflow while stopped");
    property p_sticky; $fell(overflow_irq) |-> $rose(s_axi_bvalid); endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without a write");
    property p_resp;
        s_axi_bvalid |-> s_axi_bresp == (mapped ? `TMZ_RESP_OK : `TMZ_RESP_ERR);
    endproperty
    a_resp: assert property (p_resp) else $error("wrong write response");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_refuse: assert property (p_refuse) else $error("write taken with response pending");
    // main scenarios reached
    c_ovf: cover property ($rose(overflow_irq));
    c_wake: cover property (green_wake);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == `TMZ_RESP_ERR);
endmodule

bind tmz_timer tmz_timer_checker tmz_timer_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .green_mode(green_mode),
    .pwm_pin_oe(pwm_pin_oe), .overflow_irq(overflow_irq), .green_wake(green_wake),
    .ext_int_flag(ext_int_flag));

// *** tb/tmz_far_end.sv ***
`timescale 1ns/1ps
// external pulse source and output pin load
module tmz_far_end (
    // clock
    input wire logic clk_sys,
    // pin from the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // toward the block and bench
    output logic event_pin,
    output logic pin_level
);
    // pull-up on the pin: released, it reads high rather than the last value
    assign pin_level = pin_oe ? pin_out : 1'b1;
    initial event_pin = 1'b0;
    // n pulses, wid cycles high and low; wid 1 is the fastest the sync can see
    task automatic pulses(input int n, input int wid);
        for (int i = 0; i < n; i++) begin
            repeat (wid) @(posedge clk_sys);
            event_pin <= 1'b1;
            repeat (wid) @(posedge clk_sys);
            event_pin <= 1'b0;
        end
    endtask
endmodule

// *** tb/tmz_timer_tb.sv ***
`timescale 1ns/1ps
`include "tmz_cfg.svh"
// self-checking bench: bus master notes answers, a monitor compares them
module tmz_timer_tb;
    import tmz_pkg::*;
    localparam logic [11:0] AM = `TMZ_ADDR_MODE, AC = `TMZ_ADDR_COUNT, AR = `TMZ_ADDR_RELOAD;
    localparam logic [11:0] AK = `TMZ_ADDR_CLKSEL, AS = `TMZ_ADDR_STATUS;
    localparam logic [1:0] ER = `TMZ_RESP_ERR;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic cpu_tick = 1'b0;
    logic hosc_tick = 1'b0;
    logic ext_int_event = 1'b0;
    logic green_mode = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic pwm_pin_out, pwm_pin_oe, overflow_irq, green_wake, ext_int_flag, event_pin, pin_level;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [31:0] rnd = 32'h9;
    logic [7:0] m, r1, r2;
    logic flip;
    int gap, hi;
    int bnd[5] = '{256, 64, 32, 16, 256};
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    tmz_timer tmz_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cpu_tick(cpu_tick), .hosc_tick(hosc_tick),
        .event_input_pin(event_pin), .ext_int_event(ext_int_event), .green_mode(green_mode),
        .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe), .overflow_irq(overflow_irq),
        .green_wake(green_wake), .ext_int_flag(ext_int_flag));
    tmz_far_end tmz_far_end_i (.clk_sys(clk_sys), .pin_out(pwm_pin_out), .pin_oe(pwm_pin_oe),
        .event_pin(event_pin), .pin_level(pin_level));

    always #50 clk_sys = ~clk_sys;
    // instruction clock at half the system rate, oscillator tick every cycle
    always @(posedge clk_sys) begin
        cpu_tick <= ~cpu_tick;
        hosc_tick <= 1'b1;
    end
    // hang guard: the longest run needs about 45000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            summarize();
        end
    end
    // each bus answer against the oldest note
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) chk("read", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, exp_b.pop_front()}, {32'h0, s_axi_bresp});
    end

    function automatic logic [7:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd[7:0];
    endfunction

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_n(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        exp_b.push_back(er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        exp_r.push_back({er, 24'h0, d});
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
    endtask

    // cycles between two wake pulses, and whether the pin flipped between them
    task automatic meas();
        logic p1;
        do @(posedge clk_sys); while (!green_wake);
        repeat (2) @(posedge clk_sys);
        p1 = pin_level;
        gap = 2;
        hi = 0;
        do begin
            @(posedge clk_sys);
            gap++;
            hi += pin_level;
        end while (!green_wake);
        repeat (2) @(posedge clk_sys);
        flip = p1 ^ pin_level;
    endtask

    // preload full scale, run to one overflow, stop and read back
    task automatic ovf_run(input logic [7:0] mode, input logic [7:0] e);
        wr(AC, 8'hFF);
        wr(AM, mode);
        do @(posedge clk_sys); while (!overflow_irq);
        wr(AM, 8'h00);
        rd(AS, 8'h03);
        wr(AS, 8'h02);
        rd(AS, 8'h02);
        rd(AC, e);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk("oe", 34'h0, {33'h0, pwm_pin_oe});
        foreach (bnd[i]) rd(i == 0 ? AM : i == 1 ? AC : i == 2 ? AR : i == 3 ? AK : AS, 8'h00);
        rd(12'h000, 8'h00, ER);
        wr(12'h004, 8'h5A, ER);
        green_mode <= 1'b1;
        // every prescale code on both paths, short pwm period so runs stay brief
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 8; c++) begin
                m = 8'h87 | 8'(c << 4);
                wr(AK, f ? 8'h06 : 8'h02);
                wr(AM, m);
                rd(AM, m);
                meas();
                chk_n("rate", 16 * (f ? 1 << (7 - c) : 1 << (9 - c)), gap);
                wr(AM, 8'h00);
            end
        end
        // pwm boundaries, then buzzer at the fastest rate
        for (int b = 0; b < 5; b++) begin
            m = b < 4 ? 8'hF1 | 8'(b << 1) : 8'hF2;
            wr(AM, m);
            meas();
            chk_n("period", bnd[b], gap);
            if (b < 4) chk_n("duty", bnd[b] - 3, hi);
            chk("oe", 34'h1, {33'h0, pwm_pin_oe});
            wr(AM, 8'h00);
        end
        chk("toggle", 34'h1, {33'h0, flip});
        r1 = xs();
        r2 = xs();
        wr(AK, 8'h00);
        wr(AS, 8'h02);
        wr(AR, r1);
        ovf_run(8'h84, r1);
        wr(AR, r2);
        repeat (600) @(posedge clk_sys);
        rd(AC, r1);
        ovf_run(8'h80, 8'h00);
        ovf_run(8'h84, r2);
        // pin interrupt seen in timer mode, held off in event mode
        wr(AS, 8'h00);
        ext_int_event <= 1'b1;
        @(posedge clk_sys);
        ext_int_event <= 1'b0;
        rd(AS, 8'h04);
        wr(AS, 8'h00);
        wr(AC, 8'h00);
        wr(AM, 8'hF8);
        tmz_far_end_i.pulses(3, 1);
        tmz_far_end_i.pulses(2, 5);
        ext_int_event <= 1'b1;
        @(posedge clk_sys);
        ext_int_event <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wr(AM, 8'h00);
        rd(AC, 8'h05);
        rd(AS, 8'h00);
        summarize();
    end
endmodule
